// file: hdl/nand_prot_regs.vh
`ifndef NAND_PROT_REGS_VH
`define NAND_PROT_REGS_VH

// Serial command opcodes
`define OP_SET_FEATURE  8'h1F
`define OP_PROG_EXEC    8'h10
`define OP_BLOCK_ERASE  8'hD8
`define OP_PAGE_READ    8'h13
`define OP_DEEP_SLEEP   8'hB9
`define OP_WAKE         8'hAB
`define OP_SOFT_RESET   8'hFF
`define OP_RESET_ARM    8'h66
`define OP_RESET_FIRE   8'h99

// Feature addresses
`define FA_PROTECT      8'hA0
`define FA_CONFIG       8'hB0

// Protection feature byte layout
`define PROT_CMP_BIT    1
`define PROT_INV_BIT    2
`define PROT_BP_LO      3
`define PROT_BP_HI      5
`define PROT_GATE_BIT   7

// Configuration feature byte layout
`define CFG_QE_BIT      0
`define CFG_ECC_BIT     4
`define CFG_LOCK_BIT    7

// Power-on values
`define BP_RESET        3'h7
`define INV_RESET       1'h0
`define CMP_RESET       1'h0
`define GATE_RESET      1'h0
`define QE_RESET        1'h0
`define ECC_RESET       1'h1
`define PIN_IDLE        4'hA

// Frame lengths in serial clock edges
`define CMD_BITS        6'h08
`define FEAT_BITS       6'h18
`define ADDR_BITS       6'h20
`define OPC_LAST_BIT    6'h07
`define BITCNT_MAX      6'h3F

// Row space and protection spans
`define ROW_W           18
`define ROW_SPAN        19'h40000
`define SPAN_1_64       19'h01000
`define BLOCK0_ROWS     19'h00040
`define BP_NONE         3'h0
`define BP_HALF         3'h6
`define BP_ALL          3'h7

// Cache parity byte range
`define PARITY_FIRST    12'h840
`define PARITY_LAST     12'h87F

// Correction outcome codes
`define ECC_CLEAN       2'h0
`define ECC_FIXED       2'h1
`define ECC_FAILED      2'h2
`define ECC_FIXED_MAX   2'h3
`define ECC_LIMIT       4'h8
`define ECC_FEW         4'h4

// Array operation codes and timer width
`define ARR_READ        2'h0
`define ARR_PROG        2'h1
`define ARR_ERASE       2'h2
`define ARR_RESET       2'h3
`define TIMER_W         20

`endif

// file: hdl/sync2.v
`timescale 1ns/10ps
module sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  // Two-stage synchroniser; resets to the idle pin levels so no false edge follows reset
  always @(posedge mclk) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // sync2

// file: hdl/prot_range_decode.v
`timescale 1ns/10ps
`include "nand_prot_regs.vh"
module prot_range_decode (
  input  wire [2:0]        level,
  input  wire              rangeFlip,
  input  wire              rangeComplement,
  input  wire [`ROW_W-1:0] row,
  output reg               locked
);

  wire [18:0] rowX  = {1'b0, row};
  wire [2:0]  shAmt = level - 3'h1;
  wire [18:0] span  = `SPAN_1_64 << shAmt;   // 1/64 doubled per level
  wire [18:0] rest  = `ROW_SPAN - span;
  wire        half  = (level == `BP_HALF);

  // Row against decoded range; levels 0 and 7 ignore flip and complement
  always @* begin
    case (level)
      `BP_NONE: locked = 1'b0;
      `BP_ALL:  locked = 1'b1;
      default: begin
        case ({rangeComplement, rangeFlip})
          2'b00:   locked = (rowX >= rest);
          2'b01:   locked = (rowX < span);
          2'b10:   locked = half ? (rowX < `BLOCK0_ROWS) : (rowX < rest);
          default: locked = half ? (rowX < `BLOCK0_ROWS) : (rowX >= span);
        endcase
      end
    endcase
  end

endmodule // prot_range_decode

// file: hdl/nand_block_lock_ecc_powerdown.v
`timescale 1ns/10ps
`include "nand_prot_regs.vh"
module nand_block_lock_ecc_powerdown #(
  parameter CLK_NS         = 20,
  parameter SLEEP_ENTRY_NS = 3000,
  parameter SLEEP_EXIT_NS  = 20000,
  parameter [`TIMER_W-1:0] READ_CYCLES  = 20'h004E2,
  parameter [`TIMER_W-1:0] PROG_CYCLES  = 20'h07530,
  parameter [`TIMER_W-1:0] ERASE_CYCLES = 20'h249F0,
  parameter [`TIMER_W-1:0] RESET_CYCLES = 20'h000FA
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              sck,
  input  wire              csN,
  input  wire              mosi,
  input  wire              wpN,
  input  wire              cacheWrEn,
  input  wire [11:0]       cacheWrAddr,
  input  wire [3:0]        eccErrCount,
  output wire              cacheWrAllow,
  output reg               arrayStart,
  output reg  [1:0]        arrayOp,
  output reg  [`ROW_W-1:0] arrayRow,
  output reg               eccParityGen,
  output reg               eccCheckStart,
  output reg               operationBusyFlag,
  output reg               eraseFail,
  output reg               programFail,
  output reg  [1:0]        eccStatus,
  output reg  [1:0]        eccStatusDetail,
  output reg  [2:0]        protectLevel,
  output reg               protectRangeFlip,
  output reg               protectRangeComplement,
  output reg               protectPinGateEnable,
  output reg               protectionLockdown,
  output reg               quadIoEnable,
  output reg               eccEnable,
  output reg               deepSleepActive,
  output reg               wakeInProgress
);

  // Sleep delays in cycles; least times round up
  localparam integer        ENTRY_RAW = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam integer        EXIT_RAW  = (SLEEP_EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam [`TIMER_W-1:0] ENTRY_CNT = ENTRY_RAW[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] EXIT_CNT  = EXIT_RAW[`TIMER_W-1:0];

  // Power states
  localparam [1:0] PWR_ACTIVE = 2'b00;
  localparam [1:0] PWR_ENTER  = 2'b01;
  localparam [1:0] PWR_SLEEP  = 2'b10;
  localparam [1:0] PWR_WAKE   = 2'b11;

  wire [3:0]          pinSync;
  wire                sckS = pinSync[0];
  wire                csS  = pinSync[1];
  wire                mosiS = pinSync[2];
  wire                wpS  = pinSync[3];
  reg                 sckLast;
  reg                 csLast;
  reg  [5:0]          bitCount;
  reg  [31:0]         shifter;
  reg  [7:0]          opcode;
  reg                 resetArmed;
  reg  [1:0]          pwrState;
  reg  [`TIMER_W-1:0] pwrTimer;
  reg  [`TIMER_W-1:0] opTimer;
  reg  [1:0]          curOp;
  wire                rowLocked;
  wire [3:0]          detailFull = eccErrCount - `ECC_FEW;

  // Pins cross into the mclk domain before anything looks at them
  sync2 #(
    .WIDTH     (4),
    .RESET_VAL (`PIN_IDLE)
  ) pinSyncer (
    .mclk (mclk),
    .rst  (rst),
    .din  ({wpN, mosi, csN, sck}),
    .dout (pinSync)
  );

  // Edge finding on the synchronised serial clock and chip select
  wire sckRise = sckS & ~sckLast;
  wire csRise  = csS & ~csLast;
  wire csFall  = ~csS & csLast;

  always @(posedge mclk) begin
    if (rst) begin
      sckLast <= 1'b0;
      csLast  <= 1'b1;
    end else begin
      sckLast <= sckS;
      csLast  <= csS;
    end
  end

  // Frame shifter; count saturates so long bursts never alias a short frame
  always @(posedge mclk) begin
    if (rst) begin
      bitCount <= 6'h00;
      shifter  <= 32'h00000000;
      opcode   <= 8'h00;
    end else if (csFall) begin
      bitCount <= 6'h00;
    end else if (~csS & sckRise) begin
      shifter <= {shifter[30:0], mosiS};
      if (bitCount != `BITCNT_MAX)
        bitCount <= bitCount + 6'h01;
      if (bitCount == `OPC_LAST_BIT)
        opcode <= {shifter[6:0], mosiS};
    end
  end

  // Frame fields, valid at the rising chip select that ends the frame
  wire [7:0]        featAddr = shifter[15:8];
  wire [7:0]        featData = shifter[7:0];
  wire [`ROW_W-1:0] rowIn    = shifter[`ROW_W-1:0];
  wire              byteCmd  = csRise & (bitCount == `CMD_BITS);
  wire              featCmd  = csRise & (bitCount == `FEAT_BITS) &
                               (opcode == `OP_SET_FEATURE);
  wire              addrCmd  = csRise & (bitCount == `ADDR_BITS);
  wire              active   = (pwrState == PWR_ACTIVE);
  wire              inSleep  = (pwrState == PWR_SLEEP);

  // Reset commands are honoured both awake and asleep
  wire softReset = byteCmd & (active | inSleep) & (opcode == `OP_SOFT_RESET);
  wire podReset  = byteCmd & (active | inSleep) & resetArmed &
                   (opcode == `OP_RESET_FIRE);
  wire anyReset  = softReset | podReset;

  // Array commands need an awake, idle device
  wire progCmd  = addrCmd & active & ~operationBusyFlag & (opcode == `OP_PROG_EXEC);
  wire eraseCmd = addrCmd & active & ~operationBusyFlag & (opcode == `OP_BLOCK_ERASE);
  wire readCmd  = addrCmd & active & ~operationBusyFlag & (opcode == `OP_PAGE_READ);
  wire sleepCmd = byteCmd & active & ~operationBusyFlag &
                  (opcode == `OP_DEEP_SLEEP);
  wire wakeCmd  = byteCmd & inSleep & ~operationBusyFlag & (opcode == `OP_WAKE);

  // Protection bits are frozen against feature writes by lockdown, or by the gated pin while quad I/O is off
  wire pinGuard  = protectPinGateEnable & ~wpS & ~quadIoEnable;
  wire protBlock = protectionLockdown | pinGuard;
  wire protWrite = featCmd & active & (featAddr == `FA_PROTECT) & ~protBlock;
  wire cfgWrite  = featCmd & active & (featAddr == `FA_CONFIG);

  // Locked range check against the row of the incoming frame
  prot_range_decode rangeCheck (
    .level           (protectLevel),
    .rangeFlip       (protectRangeFlip),
    .rangeComplement (protectRangeComplement),
    .row             (rowIn),
    .locked          (rowLocked)
  );

  // Parity bytes stay read-only while correction is on
  wire parityHit = (cacheWrAddr >= `PARITY_FIRST) & (cacheWrAddr <= `PARITY_LAST);
  assign cacheWrAllow = cacheWrEn & ~(eccEnable & parityHit);

  // Reset arming for the 66h/99h pair; any other complete frame disarms
  always @(posedge mclk) begin
    if (rst)
      resetArmed <= 1'b0;
    else if (csRise & (bitCount != 6'h00))
      resetArmed <= byteCmd & (active | inSleep) & (opcode == `OP_RESET_ARM);
  end

  // Protection feature byte
  always @(posedge mclk) begin
    if (rst) begin
      protectLevel           <= `BP_RESET;
      protectRangeFlip       <= `INV_RESET;
      protectRangeComplement <= `CMP_RESET;
      protectPinGateEnable   <= `GATE_RESET;
    end else if (podReset) begin
      protectLevel           <= `BP_RESET;
      protectRangeFlip       <= `INV_RESET;
      protectRangeComplement <= `CMP_RESET;
      protectPinGateEnable   <= `GATE_RESET;
    end else if (protWrite) begin
      protectLevel           <= featData[`PROT_BP_HI:`PROT_BP_LO];
      protectRangeFlip       <= featData[`PROT_INV_BIT];
      protectRangeComplement <= featData[`PROT_CMP_BIT];
      protectPinGateEnable   <= featData[`PROT_GATE_BIT];
    end
  end

  // Configuration byte; lockdown only ever sets, so only rst clears it
  always @(posedge mclk) begin
    if (rst) begin
      quadIoEnable       <= `QE_RESET;
      eccEnable          <= `ECC_RESET;
      protectionLockdown <= 1'b0;
    end else if (podReset) begin
      quadIoEnable <= `QE_RESET;
      eccEnable    <= `ECC_RESET;
    end else if (cfgWrite) begin
      quadIoEnable       <= featData[`CFG_QE_BIT];
      eccEnable          <= featData[`CFG_ECC_BIT];
      protectionLockdown <= protectionLockdown | featData[`CFG_LOCK_BIT];
    end
  end

  // Array sequencer: start pulse, busy flag and duration timer
  always @(posedge mclk) begin
    if (rst) begin
      arrayStart        <= 1'b0;
      arrayOp           <= `ARR_READ;
      arrayRow          <= {`ROW_W{1'b0}};
      curOp             <= `ARR_READ;
      opTimer           <= {`TIMER_W{1'b0}};
      operationBusyFlag <= 1'b0;
      eccParityGen      <= 1'b0;
      eccCheckStart     <= 1'b0;
    end else begin
      arrayStart    <= 1'b0;
      eccParityGen  <= 1'b0;
      eccCheckStart <= 1'b0;
      if (anyReset) begin
        // A reset restarts the timer even over a running cycle
        arrayStart        <= 1'b1;
        arrayOp           <= `ARR_RESET;
        curOp             <= `ARR_RESET;
        opTimer           <= RESET_CYCLES;
        operationBusyFlag <= 1'b1;
      end else if ((progCmd | eraseCmd) & ~rowLocked) begin
        arrayStart        <= 1'b1;
        arrayOp           <= progCmd ? `ARR_PROG : `ARR_ERASE;
        curOp             <= progCmd ? `ARR_PROG : `ARR_ERASE;
        arrayRow          <= rowIn;
        opTimer           <= progCmd ? PROG_CYCLES : ERASE_CYCLES;
        operationBusyFlag <= 1'b1;
        eccParityGen      <= progCmd & eccEnable;
      end else if (readCmd) begin
        arrayStart        <= 1'b1;
        arrayOp           <= `ARR_READ;
        curOp             <= `ARR_READ;
        arrayRow          <= rowIn;
        opTimer           <= READ_CYCLES;
        operationBusyFlag <= 1'b1;
      end else if (operationBusyFlag) begin
        if (opTimer <= 20'h00001) begin
          operationBusyFlag <= 1'b0;
          eccCheckStart     <= (curOp == `ARR_READ) & eccEnable;
        end else begin
          opTimer <= opTimer - 20'h00001;
        end
      end
      // Locked targets fall through above: busy stays low, no start
    end
  end

  // Erase fail updates on the next erase frame, program fail on the next program frame
  always @(posedge mclk) begin
    if (rst) begin
      eraseFail   <= 1'b0;
      programFail <= 1'b0;
    end else begin
      if (eraseCmd)
        eraseFail <= rowLocked;
      if (progCmd)
        programFail <= rowLocked;
    end
  end

  // Correction outcome, latched when the read cycle finishes
  always @(posedge mclk) begin
    if (rst) begin
      eccStatus       <= `ECC_CLEAN;
      eccStatusDetail <= 2'h0;
    end else if (operationBusyFlag & (opTimer <= 20'h00001) & ~anyReset &
                 (curOp == `ARR_READ)) begin
      eccStatusDetail <= 2'h0;
      if (~eccEnable || eccErrCount == 4'h0) begin
        eccStatus <= `ECC_CLEAN;
      end else if (eccErrCount > `ECC_LIMIT) begin
        eccStatus <= `ECC_FAILED;
      end else if (eccErrCount == `ECC_LIMIT) begin
        eccStatus <= `ECC_FIXED_MAX;
      end else begin
        eccStatus <= `ECC_FIXED;
        if (eccErrCount > `ECC_FEW)
          eccStatusDetail <= detailFull[1:0];                            // 5..7 map to 1..3
      end
    end
  end

  // Power state: entry delay after chip select, exit delay after wake
  always @(posedge mclk) begin
    if (rst) begin
      pwrState        <= PWR_ACTIVE;
      pwrTimer        <= {`TIMER_W{1'b0}};
      deepSleepActive <= 1'b0;
      wakeInProgress  <= 1'b0;
    end else begin
      case (pwrState)
        PWR_ACTIVE: begin
          if (sleepCmd) begin
            pwrState <= PWR_ENTER;
            pwrTimer <= ENTRY_CNT;
          end
        end
        PWR_ENTER: begin
          // Frames during the entry delay are not decoded
          if (pwrTimer <= 20'h00001) begin
            pwrState        <= PWR_SLEEP;
            deepSleepActive <= 1'b1;
          end else begin
            pwrTimer <= pwrTimer - 20'h00001;
          end
        end
        PWR_SLEEP: begin
          if (anyReset) begin
            pwrState        <= PWR_ACTIVE;
            deepSleepActive <= 1'b0;
          end else if (wakeCmd) begin
            pwrState       <= PWR_WAKE;
            pwrTimer       <= EXIT_CNT;
            wakeInProgress <= 1'b1;
          end
        end
        PWR_WAKE: begin
          // Host keeps chip select high here; frames are dropped
          if (pwrTimer <= 20'h00001) begin
            pwrState        <= PWR_ACTIVE;
            deepSleepActive <= 1'b0;
            wakeInProgress  <= 1'b0;
          end else begin
            pwrTimer <= pwrTimer - 20'h00001;
          end
        end
        default: begin
          pwrState        <= PWR_ACTIVE;
          deepSleepActive <= 1'b0;
          wakeInProgress  <= 1'b0;
        end
      endcase
    end
  end

endmodule // nand_block_lock_ecc_powerdown

// file: testbench/nand_prot_checker_assertions.sv
`timescale 1ns/10ps
module nand_prot_checker (
  input wire        mclk,
  input wire        rst,
  input wire        cacheWrEn,
  input wire [11:0] cacheWrAddr,
  input wire        cacheWrAllow,
  input wire        arrayStart,
  input wire [1:0]  arrayOp,
  input wire        eccParityGen,
  input wire        eccCheckStart,
  input wire        operationBusyFlag,
  input wire        eraseFail,
  input wire [2:0]  protectLevel,
  input wire        protectionLockdown,
  input wire        eccEnable,
  input wire        deepSleepActive,
  input wire        wakeInProgress
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A launch must show busy at once and last a single cycle
  a_start_sets_busy: assert property (arrayStart |-> operationBusyFlag ##1 !arrayStart)
    else $error("array start without busy");
  a_busy_has_cause: assert property ($rose(operationBusyFlag) |-> arrayStart)
    else $error("busy rose without a launch");
  a_parity_on_prog: assert property (arrayStart && arrayOp == 2'h1 |-> eccParityGen == eccEnable)
    else $error("parity pulse wrong at program");
  a_parity_guarded: assert property (cacheWrEn && eccEnable && cacheWrAddr >= 12'h840
    && cacheWrAddr <= 12'h87F |-> !cacheWrAllow)
    else $error("parity byte write let through");
  a_page_open: assert property (cacheWrEn && !eccEnable |-> cacheWrAllow)
    else $error("write refused with correction off");
  a_fail_no_launch: assert property ($rose(eraseFail) |-> !arrayStart && !operationBusyFlag)
    else $error("locked erase started");
  // Reset pair may restore the level together with its own launch
  a_lock_frozen: assert property (protectionLockdown |=> protectionLockdown
    && ($stable(protectLevel) || arrayStart))
    else $error("lockdown let level change");
  a_sleep_quiet: assert property (deepSleepActive |-> !arrayStart || arrayOp == 2'h3)
    else $error("array op launched in sleep");
  a_wake_in_sleep: assert property (wakeInProgress |-> deepSleepActive)
    else $error("wake delay outside sleep");
  // Check pulse only as a corrected read finishes
  a_check_after_read: assert property (eccCheckStart |-> !operationBusyFlag
    && $past(operationBusyFlag) && arrayOp == 2'h0 && eccEnable)
    else $error("check pulse outside read end");
endmodule // nand_prot_checker

bind nand_block_lock_ecc_powerdown nand_prot_checker nand_prot_checker_inst (
  .mclk(mclk), .rst(rst), .cacheWrEn(cacheWrEn), .cacheWrAddr(cacheWrAddr),
  .cacheWrAllow(cacheWrAllow), .arrayStart(arrayStart), .arrayOp(arrayOp),
  .eccParityGen(eccParityGen), .eccCheckStart(eccCheckStart),
  .operationBusyFlag(operationBusyFlag), .eraseFail(eraseFail),
  .protectLevel(protectLevel), .protectionLockdown(protectionLockdown),
  .eccEnable(eccEnable), .deepSleepActive(deepSleepActive), .wakeInProgress(wakeInProgress)
);

// file: testbench/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
  input  wire mclk,
  output reg  sck,
  output reg  csN,
  output reg  mosi
);
  // Link clock stands low between frames
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // Half of the 160 ns link period
  task automatic half;
    repeat (4) @(posedge mclk);
  endtask
  // One frame MSB first; data set a half period before each rise
  task automatic send(input [31:0] word, input integer n);
    integer i;
    begin
      csN <= 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        mosi <= word[i];
        half;
        sck <= 1'b1;
        half;
        sck <= 1'b0;
      end
      half;
      csN <= 1'b1; // Raised a half period after the last clock fall
      mosi <= ~mosi; // Released line shows no stale value
      repeat (8) @(posedge mclk);
    end
  endtask
endmodule // spi_host_model

// file: testbench/nand_block_lock_ecc_powerdown_test.sv
`timescale 1ns/10ps
`include "nand_prot_regs.vh"
`define CHK(nm, xp, sn) begin compares = compares + 1; if ((sn) !== (xp)) begin \
  bad_count = bad_count + 1; $display("Error %s expected %0h seen %0h", nm, xp, sn); end end
module nand_block_lock_ecc_powerdown_test;
  reg         mclk, rst, wpN, cacheWrEn, fl, cm, er, ex;
  reg  [11:0] cacheWrAddr;
  reg  [3:0]  eccErrCount;
  reg  [17:0] row;
  reg  [2:0]  lv;
  wire        sck, csN, mosi, cacheWrAllow, arrayStart, eccParityGen, eccCheckStart;
  wire        operationBusyFlag, eraseFail, programFail, protectRangeFlip;
  wire        protectRangeComplement, protectPinGateEnable, protectionLockdown;
  wire        quadIoEnable, eccEnable, deepSleepActive, wakeInProgress;
  wire [1:0]  arrayOp, eccStatus, eccStatusDetail;
  wire [2:0]  protectLevel;
  wire [17:0] arrayRow;
  integer     bad_count = 0, compares = 0, i, k;

  // Short array times keep the run small; reset time keeps its default
  nand_block_lock_ecc_powerdown #(.SLEEP_ENTRY_NS(100), .SLEEP_EXIT_NS(200),
    .READ_CYCLES(20'h00014), .PROG_CYCLES(20'h00014), .ERASE_CYCLES(20'h0012C))
    nand_block_lock_ecc_powerdown_inst (.mclk, .rst, .sck, .csN,
    .mosi, .wpN, .cacheWrEn, .cacheWrAddr, .eccErrCount, .cacheWrAllow, .arrayStart,
    .arrayOp, .arrayRow, .eccParityGen, .eccCheckStart, .operationBusyFlag, .eraseFail,
    .programFail, .eccStatus, .eccStatusDetail, .protectLevel, .protectRangeFlip,
    .protectRangeComplement, .protectPinGateEnable, .protectionLockdown, .quadIoEnable,
    .eccEnable, .deepSleepActive, .wakeInProgress);
  spi_host_model spi_host_model_inst (.mclk, .sck, .csN, .mosi);

  // Expected lock: lower span when flip and complement differ
  function automatic lockExp(input [2:0] l, input f, input c, input [17:0] r);
    reg [18:0] s;
    begin
      s = 19'h00800 << l;
      s = f ? s : 19'h40000 - s;
      if (l == 3'h0) lockExp = 1'b0;
      else if (l == 3'h7) lockExp = 1'b1;
      else if (c && l == 3'h6) lockExp = r < 18'h00040;
      else lockExp = (f ^ c) ? ({1'b0, r} < s) : ({1'b0, r} >= s);
    end
  endfunction
  // Status and detail for an error count; detail only kept for code 01
  function automatic [3:0] eccExp(input [3:0] n);
    eccExp = n == 4'h0 ? 4'h0 : n > 4'h8 ? 4'h8 : n == 4'h8 ? 4'hC :
      n <= 4'h4 ? 4'h4 : {2'h1, n[1:0]};
  endfunction
  task automatic feat(input [7:0] a, input [7:0] d);
    spi_host_model_inst.send({8'h00, `OP_SET_FEATURE, a, d}, 24);
  endtask
  task automatic arr(input [7:0] op, input [17:0] r);
    spi_host_model_inst.send({op, 6'h00, r}, 32);
  endtask
  task automatic sleepCmd(input [7:0] op);
    spi_host_model_inst.send({24'h000000, op}, 8);
    repeat (30) @(posedge mclk);
  endtask
  // Bounded wait for the array to go idle
  task automatic idle;
    k = 0;
    while (operationBusyFlag !== 1'b0 && k < 1000) begin
      @(posedge mclk);
      k = k + 1;
    end
    `CHK("idle", 1'b0, operationBusyFlag)
  endtask
  task automatic test_done;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #1600000; // About twice the expected run
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    rst = 1'b1;
    wpN = 1'b1;
    cacheWrEn = 1'b0;
    cacheWrAddr = 12'h000;
    eccErrCount = 4'h0;
    i = $urandom(89);
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("level", 3'h7, protectLevel)
    `CHK("bits", 4'h0, {protectRangeFlip, protectRangeComplement, protectPinGateEnable, quadIoEnable})
    `CHK("ecc", 1'b1, eccEnable)
    $display("Test reset done");
    // Every level, flip and complement, with random and boundary rows
    for (i = 0; i < 64; i = i + 1) begin
      lv = i[2:0];
      fl = i[3];
      cm = i[4];
      er = $urandom;
      feat(`FA_PROTECT, {2'h0, lv, fl, cm, 1'b0});
      `CHK("level", lv, protectLevel)
      row = $urandom;
      if (i[5]) row = (fl ? 19'h00800 << lv : 19'h40000 - (19'h00800 << lv)) - {18'h0, er};
      ex = lockExp(lv, fl, cm, row);
      arr(er ? `OP_BLOCK_ERASE : `OP_PROG_EXEC, row);
      `CHK("busy", !ex, operationBusyFlag)
      `CHK("fail", ex, er ? eraseFail : programFail)
      if (!ex) `CHK("row", row, arrayRow)
      idle;
    end
    $display("Test lock done");
    feat(`FA_PROTECT, 8'h80);
    wpN <= 1'b0;
    feat(`FA_PROTECT, 8'hA8);
    `CHK("wp", 3'h0, protectLevel)
    feat(`FA_CONFIG, 8'h11);
    feat(`FA_PROTECT, 8'hA8);
    `CHK("quad", 3'h5, protectLevel)
    feat(`FA_CONFIG, 8'h10);
    wpN <= 1'b1;
    feat(`FA_PROTECT, 8'h00);
    $display("Test pin done");
    // Cache guard around the parity bytes, correction off then on
    for (i = 0; i < 200; i = i + 1) begin
      if (i % 100 == 0) feat(`FA_CONFIG, i ? 8'h10 : 8'h00);
      if (i % 100 == 0) `CHK("ecc", i != 0, eccEnable)
      cacheWrEn <= $urandom;
      cacheWrAddr <= 12'h830 + $urandom % 96;
      @(posedge mclk);
      ex = cacheWrEn & ~(i >= 100 && cacheWrAddr >= 12'h840 && cacheWrAddr <= 12'h87F);
      `CHK("guard", ex, cacheWrAllow)
    end
    cacheWrEn <= 1'b0;
    $display("Test guard done");
    for (i = 0; i < 8; i = i + 1) begin
      eccErrCount <= 32'h0456789F >> (4 * i);
      arr(`OP_PAGE_READ, $urandom);
      idle;
      repeat (3) @(posedge mclk);
      `CHK("status", eccExp(eccErrCount), {eccStatus, eccStatus == 2'h1 ? eccStatusDetail : 2'h0})
    end
    $display("Test ecc done");
    arr(`OP_BLOCK_ERASE, 18'h00000);
    sleepCmd(`OP_DEEP_SLEEP);
    idle;
    `CHK("busy sleep", 1'b0, deepSleepActive)
    spi_host_model_inst.send({16'h0000, `OP_DEEP_SLEEP, 8'h00}, 16);
    repeat (30) @(posedge mclk);
    `CHK("long frame", 1'b0, deepSleepActive)
    sleepCmd(`OP_DEEP_SLEEP);
    `CHK("sleep", 1'b1, deepSleepActive)
    arr(`OP_PROG_EXEC, 18'h00010);
    `CHK("ignored", 1'b0, operationBusyFlag)
    sleepCmd(`OP_WAKE); // Chip select kept high well past the exit delay
    `CHK("wake", 1'b0, deepSleepActive)
    sleepCmd(`OP_DEEP_SLEEP);
    sleepCmd(`OP_SOFT_RESET);
    idle;
    `CHK("soft", 1'b0, deepSleepActive)
    feat(`FA_PROTECT, 8'h10);
    sleepCmd(`OP_DEEP_SLEEP);
    sleepCmd(`OP_RESET_ARM);
    sleepCmd(`OP_RESET_FIRE);
    idle;
    `CHK("pair", 4'hE, {protectLevel, deepSleepActive})
    $display("Test sleep done");
    feat(`FA_CONFIG, 8'h90);
    feat(`FA_PROTECT, 8'h00);
    `CHK("lockdown", 4'hF, {protectLevel, protectionLockdown})
    $display("Test lockdown done");
    test_done;
  end
endmodule // nand_block_lock_ecc_powerdown_test
